// >>> dv/nvdar_top_tb_top.sv
// Self-checking testbench for the memory data and address holding registers
`timescale 1ns/1ps
`default_nettype none
module nvdar_top_tb_top
    import nvdar_pkg::*;
;
    // ------------------------------------------------------------
    // Signals and bench state
    // ------------------------------------------------------------
    logic        pclk;                // Core clock, 25 ns
    logic        presetn;             // Any-reset, active low
    logic        por_n;               // Power-on reset, active low
    logic        psel;                // APB select
    logic        penable;             // APB access phase
    logic        pwrite;              // APB direction
    logic [7:0]  paddr;               // APB address
    logic [31:0] pwdata;              // APB write data
    logic [31:0] prdata;              // APB read data
    logic        pready;              // APB ready
    logic        pslverr;             // APB error
    logic        rd_start;            // Memory read request
    logic        config_space_select; // Config space target
    logic [14:0] nvm_address_word;    // Address seen by memory
    logic        mem_done;            // Memory word ready
    logic [13:0] mem_rdata;           // Word from memory
    logic [13:0] nvm_data_word;       // Data word to memory
    int          miscompares = 0;     // Mismatch count
    int          compares    = 0;     // Comparison count
    int          cycles      = 0;     // Timeout counter
    logic [31:0] seed = 32'h00000e8f; // Fixed xorshift seed
    logic [7:0]  model [4];           // Expected register contents
    logic [7:0]  offs  [4] = '{NVDAR_OFF_DATA_LOW, NVDAR_OFF_DATA_HIGH, NVDAR_OFF_ADDRESS_LOW, NVDAR_OFF_ADDRESS_HIGH};
    logic [7:0]  msk   [4] = '{8'hff, NVDAR_DATA_HI_MSK, 8'hff, NVDAR_ADDR_HI_MSK};

    nvdar_top nvdar_top_inst (.pclk(pclk), .presetn(presetn), .por_n(por_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rd_start(rd_start), .config_space_select(config_space_select), .nvm_address_word(nvm_address_word),
        .mem_done(mem_done), .mem_rdata(mem_rdata), .nvm_data_word(nvm_data_word));

    // ------------------------------------------------------------
    // Clock, timeout and helpers
    // ------------------------------------------------------------
    // Free-running core clock
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // Hang guard, far above the few hundred cycles needed
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            end_sim();
        end
    end

    // Repeatable xorshift source
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Config space readable offsets: 0-3 and 6-8 with zero high part
    function automatic logic cfg_ok(input logic [7:0] hi, input logic [7:0] lo);
        return (hi == 8'h00) && ((lo <= 8'h03) || ((lo >= 8'h06) && (lo <= 8'h08)));
    endfunction

    // Single comparison point
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Verdict and end of run
    task automatic end_sim();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Bus and memory drivers
    // ------------------------------------------------------------
    // One APB transfer; entered and left just after a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
        logic rdy;
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Answer looked at on the falling edge: settled there, and the
        // same values that the next rising edge samples
        do begin
            @(negedge pclk);
            rdy = pready;
            q   = prdata;
            err = pslverr;
            @(posedge pclk);
        end while (rdy !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Read a register and compare the whole word
    task automatic rd_chk(input string name, input int i);
        logic [31:0] q;
        logic        e;
        apb(1'b0, offs[i], 32'h0, q, e);
        check(name, {31'h0, e}, 32'h0);
        check(name, q, {24'h0, model[i]});
    endtask

    // Software write with the bench model following the implemented bits
    task automatic wr_reg(input int i, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, offs[i], d, q, e);
        model[i] = d[7:0] & msk[i];
    endtask

    // Memory read handshake; mem_rdata is scrambled once the word is taken
    task automatic mem_read(input logic [13:0] w);
        rd_start  <= 1'b1;
        @(posedge pclk);
        rd_start  <= 1'b0;
        mem_done  <= 1'b1;
        mem_rdata <= w;
        @(posedge pclk);
        mem_done  <= 1'b0;
        mem_rdata <= ~w;
        repeat (3) @(posedge pclk);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] q;
        logic [31:0] r;
        logic [13:0] w;
        logic        e;
        logic        bad;
        {presetn, por_n, psel, penable, pwrite, rd_start, config_space_select, mem_done} = 8'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        mem_rdata = 14'h0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        por_n   <= 1'b1;
        repeat (4) @(posedge pclk);
        // Reset values: address cleared, data at chosen power-on value
        model = '{NVDAR_DATA_POR, NVDAR_DATA_POR, NVDAR_ADDR_RST, NVDAR_ADDR_RST};
        for (int i = 0; i < 4; i++) rd_chk("reset value", i);
        // Corner fills, then random traffic
        for (int k = 0; k < 28; k++) begin
            r = (k < 8) ? ((k[0]) ? 32'h0 : 32'hffffffff) : rnd();
            wr_reg((k < 8) ? k / 2 : r[9:8], r);
            if (k < 8 || r[10]) rd_chk("register readback", (k < 8) ? k / 2 : r[9:8]);
        end
        check("address port", {17'h0, nvm_address_word}, {17'h0, model[3][6:0], model[2]});
        check("data port", {18'h0, nvm_data_word}, {18'h0, model[1][5:0], model[0]});
        // Unmapped offset refused
        apb(1'b1, 8'h14, 32'h5a, q, e);
        check("unmapped write err", {31'h0, e}, 32'h1);
        apb(1'b0, 8'h14, 32'h0, q, e);
        check("unmapped read", q, 32'h0);
        check("unmapped read err", {31'h0, e}, 32'h1);
        for (int i = 0; i < 4; i++) rd_chk("after unmapped", i);
        // Memory reads, plain and config space, with software verify
        for (int k = 0; k < 12; k++) begin
            r = rnd();
            w = r[13:0];
            config_space_select <= (k < 3) ? 1'b1 : r[14];
            wr_reg(2, (k == 0) ? 32'h4 : (k == 1) ? 32'h6 : (k == 2) ? 32'h8 : {24'h0, r[23:16]});
            wr_reg(3, (k < 3 || r[15]) ? 32'h0 : {25'h0, r[30:24]});
            bad = config_space_select && !cfg_ok(model[3], model[2]);
            mem_read(w);
            model[0] = bad ? 8'h00 : w[7:0];
            model[1] = bad ? 8'h00 : {2'b00, w[13:8]};
            rd_chk("read data low", 0);
            rd_chk("read data high", 1);
            apb(1'b0, NVDAR_OFF_STATUS, 32'h0, q, e);
            check("out of range flag", {31'h0, q[NVDAR_ST_CLEAR]}, {31'h0, bad});
            check("busy flag", {31'h0, q[NVDAR_ST_BUSY]}, 32'h0);
            check("data port after read", {18'h0, nvm_data_word}, {18'h0, model[1][5:0], model[0]});
        end
        config_space_select <= 1'b0;
        // Other reset: address clears, data kept
        wr_reg(2, 32'h3c);
        wr_reg(3, 32'h55);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        model[2] = NVDAR_ADDR_RST;
        model[3] = NVDAR_ADDR_RST;
        for (int i = 0; i < 4; i++) rd_chk("after presetn", i);
        // Power-on reset: data back to power-on value
        por_n   <= 1'b0;
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        por_n   <= 1'b1;
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        model = '{NVDAR_DATA_POR, NVDAR_DATA_POR, NVDAR_ADDR_RST, NVDAR_ADDR_RST};
        for (int i = 0; i < 4; i++) rd_chk("after power-on", i);
        end_sim();
    end
endmodule
`default_nettype wire

// >>> hdl/nvdar_apb_slave.sv
// APB slave front end: decodes setup/access phases into single-cycle strobes
`timescale 1ns/1ps
`default_nettype none
module nvdar_apb_slave
    import nvdar_pkg::*;
(
    input  wire logic        pclk,       // Core clock
    input  wire logic        presetn,    // Async reset, active low
    input  wire logic        psel,       // APB select
    input  wire logic        penable,    // APB access phase
    input  wire logic        pwrite,     // APB direction
    input  wire logic [7:0]  paddr,      // APB byte address
    output logic             pready,     // Writes zero wait, reads one wait state
    output logic             pslverr,    // Error for unmapped address
    output logic             wr_stb,     // Write takes effect this edge
    output logic             rd_stb,     // Read data captured this edge
    output logic [7:0]       acc_addr    // Address of the access
);

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic access;                         // Access phase qualifier
    logic mapped;                         // Address hits a register
    logic rd_wait_reg;                    // Read data registered, answer now
    logic rd_wait_next;                   // Next value of the read wait flag

    // Reads take one wait state: read data is a flop loaded in the first
    // access cycle, so it has settled by the time pready rises
    always_comb begin
        access       = psel && penable;
        mapped       = (paddr == NVDAR_OFF_DATA_LOW)    || (paddr == NVDAR_OFF_DATA_HIGH) ||
                       (paddr == NVDAR_OFF_ADDRESS_LOW) || (paddr == NVDAR_OFF_ADDRESS_HIGH) ||
                       (paddr == NVDAR_OFF_STATUS);
        rd_wait_next = access && !pwrite && !rd_wait_reg;
        pready       = access && (pwrite || rd_wait_reg);
        pslverr      = pready && !mapped;
        wr_stb       = access && pwrite && mapped;
        rd_stb       = access && !pwrite && !rd_wait_reg;
        acc_addr     = paddr;
    end

    // Read wait flag; clears on the answering edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_wait_reg <= 1'b0;
        end else begin
            rd_wait_reg <= rd_wait_next;
        end
    end

endmodule
`default_nettype wire

// >>> hdl/nvdar_pkg.sv
// Package: register map, field layouts and reset values of the memory holding registers
package nvdar_pkg;

    // ------------------------------------------------------------
    // Register byte offsets (one aligned word each)
    // ------------------------------------------------------------
    localparam logic [7:0] NVDAR_OFF_DATA_LOW     = 8'h00; // Low data byte
    localparam logic [7:0] NVDAR_OFF_DATA_HIGH    = 8'h04; // High data bits
    localparam logic [7:0] NVDAR_OFF_ADDRESS_LOW  = 8'h08; // Low address byte
    localparam logic [7:0] NVDAR_OFF_ADDRESS_HIGH = 8'h0c; // High address bits
    localparam logic [7:0] NVDAR_OFF_STATUS       = 8'h10; // Read state and last result

    // ------------------------------------------------------------
    // Field widths and masks
    // ------------------------------------------------------------
    localparam int         NVDAR_DATA_W      = 14;     // Memory word width
    localparam int         NVDAR_ADDR_W      = 15;     // Address width
    localparam logic [7:0] NVDAR_DATA_HI_MSK = 8'h3f;  // Implemented high data bits
    localparam logic [7:0] NVDAR_ADDR_HI_MSK = 8'h7f;  // Implemented high address bits

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] NVDAR_ADDR_RST = 8'h00;     // Address cleared on any reset
    localparam logic [7:0] NVDAR_DATA_POR = 8'h00;     // Data value chosen at power-on

    // ------------------------------------------------------------
    // Status register bit positions
    // ------------------------------------------------------------
    localparam int NVDAR_ST_BUSY  = 0;                 // Read in progress
    localparam int NVDAR_ST_CLEAR = 1;                 // Last read was out of range

    // Read sequencer states
    typedef enum logic [1:0] {
        NVDAR_IDLE,
        NVDAR_WAIT,
        NVDAR_LOAD
    } nvdar_state_t;

endpackage

// >>> hdl/nvdar_top.sv
// Data and address holding registers of the nonvolatile memory access unit
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module nvdar_top
    import nvdar_pkg::*;
(
    input  wire logic                    pclk,           // Core clock, 40 MHz
    input  wire logic                    presetn,        // Async reset, active low (any reset)
    input  wire logic                    por_n,          // Power-on/brown-out reset, active low
    input  wire logic                    psel,           // APB select
    input  wire logic                    penable,        // APB enable
    input  wire logic                    pwrite,         // APB direction
    input  wire logic [7:0]              paddr,          // APB address
    input  wire logic [31:0]             pwdata,         // APB write data
    output logic      [31:0]             prdata,         // APB read data
    output logic                         pready,         // APB ready
    output logic                         pslverr,        // APB error
    input  wire logic                    rd_start,       // Read request from control logic
    input  wire logic                    config_space_select, // Read targets config space
    output logic      [NVDAR_ADDR_W-1:0] nvm_address_word, // Address to memory
    input  wire logic                    mem_done,       // Memory word ready
    input  wire logic [NVDAR_DATA_W-1:0] mem_rdata,      // Word from memory
    output logic      [NVDAR_DATA_W-1:0] nvm_data_word   // Data word to memory
);

    // ------------------------------------------------------------
    // Bus front end
    // ------------------------------------------------------------
    logic       wr_stb;                   // Register write strobe
    logic       rd_stb;                   // Register read strobe
    logic [7:0] acc_addr;                 // Accessed offset

    nvdar_apb_slave u_apb (
        .pclk     (pclk),
        .presetn  (presetn),
        .psel     (psel),
        .penable  (penable),
        .pwrite   (pwrite),
        .paddr    (paddr),
        .pready   (pready),
        .pslverr  (pslverr),
        .wr_stb   (wr_stb),
        .rd_stb   (rd_stb),
        .acc_addr (acc_addr)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Config space accessible: user IDs 0..3, device ID 6, config words 7..8
    function automatic logic cfg_readable(input logic [NVDAR_ADDR_W-1:0] a);
        logic [14:0] lo;
        lo = a;
        return (lo <= 15'h0003) || ((lo >= 15'h0006) && (lo <= 15'h0008));
    endfunction

    // Zero-extend an 8-bit register onto the 32-bit read bus
    function automatic logic [31:0] rd_word(input logic [7:0] v);
        return {24'h000000, v};
    endfunction

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [7:0]   data_low_reg,  data_low_next;   // Low data byte
    logic [7:0]   data_high_reg, data_high_next;  // High data, bits 5:0 live
    logic [7:0]   addr_low_reg,  addr_low_next;   // Low address byte
    logic [7:0]   addr_high_reg, addr_high_next;  // High address, bits 6:0 live
    logic [31:0]  prdata_reg,    prdata_next;     // Registered read data
    logic         cleared_reg,   cleared_next;    // Last read was out of range
    nvdar_state_t state_reg,     state_next;      // Read sequencer
    logic         por_meta,      por_sync;        // Power-on reset synchroniser

    // Outputs assembled from the registers
    always_comb begin
        nvm_address_word = {addr_high_reg[6:0], addr_low_reg};
        nvm_data_word    = {data_high_reg[5:0], data_low_reg};
        prdata           = prdata_reg;
    end

    // ------------------------------------------------------------
    // Power-on reset synchroniser
    // ------------------------------------------------------------
    // Two flops since the power-on level comes from outside logic.
    // No reset here on purpose: if the ordinary reset cleared these
    // flops, every ordinary reset would look like a power-on and wipe
    // the data registers, which must keep their contents through it
    always_ff @(posedge pclk) begin
        por_meta <= por_n;
        por_sync <= por_meta;
    end

    // ------------------------------------------------------------
    // Read sequencer
    // ------------------------------------------------------------
    // Waits for memory after a read request, then loads the word.
    // A request while busy is dropped, not queued: software polls
    // the busy bit before starting the next read
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            NVDAR_IDLE: begin
                if (rd_start) begin
                    state_next = NVDAR_WAIT;
                end
            end
            NVDAR_WAIT: begin
                if (mem_done) begin
                    state_next = NVDAR_LOAD;
                end
            end
            NVDAR_LOAD: begin
                state_next = NVDAR_IDLE;
            end
            default: begin
                state_next = NVDAR_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Register next-value logic
    // ------------------------------------------------------------
    // Memory load has priority over a same-cycle software write, so
    // a read-back verify always sees the memory contents.
    // The word is taken on the edge that sees mem_done: memory only
    // holds it on mem_rdata for that one cycle, so waiting for the
    // LOAD state would capture whatever follows it
    always_comb begin
        data_low_next  = data_low_reg;
        data_high_next = data_high_reg;
        addr_low_next  = addr_low_reg;
        addr_high_next = addr_high_reg;
        cleared_next   = cleared_reg;
        if (wr_stb) begin
            case (acc_addr)
                NVDAR_OFF_DATA_LOW:     data_low_next  = pwdata[7:0];
                NVDAR_OFF_DATA_HIGH:    data_high_next = pwdata[7:0] & NVDAR_DATA_HI_MSK;
                NVDAR_OFF_ADDRESS_LOW:  addr_low_next  = pwdata[7:0];
                NVDAR_OFF_ADDRESS_HIGH: addr_high_next = pwdata[7:0] & NVDAR_ADDR_HI_MSK;
                default: begin
                    // Status is read only
                end
            endcase
        end
        if (state_reg == NVDAR_WAIT && mem_done) begin
            if (config_space_select && !cfg_readable(nvm_address_word)) begin
                data_low_next  = 8'h00;
                data_high_next = 8'h00;
                cleared_next   = 1'b1;
            end else begin
                data_low_next  = mem_rdata[7:0];
                data_high_next = {2'b00, mem_rdata[13:8]};
                cleared_next   = 1'b0;
            end
        end
    end

    // Read mux; unmapped offsets return zero.
    // Loaded in the first access cycle of a read, which the bus front
    // end stretches by one wait state, so the word is settled by the
    // time pready rises
    always_comb begin
        prdata_next = prdata_reg;
        if (rd_stb) begin
            case (acc_addr)
                NVDAR_OFF_DATA_LOW:     prdata_next = rd_word(data_low_reg);
                NVDAR_OFF_DATA_HIGH:    prdata_next = rd_word(data_high_reg & NVDAR_DATA_HI_MSK);
                NVDAR_OFF_ADDRESS_LOW:  prdata_next = rd_word(addr_low_reg);
                NVDAR_OFF_ADDRESS_HIGH: prdata_next = rd_word(addr_high_reg & NVDAR_ADDR_HI_MSK);
                NVDAR_OFF_STATUS:       prdata_next = {30'h00000000, cleared_reg, state_reg != NVDAR_IDLE};
                default:                prdata_next = 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Address, status and sequencer registers (cleared on any reset)
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_low_reg  <= NVDAR_ADDR_RST;
            addr_high_reg <= NVDAR_ADDR_RST;
            cleared_reg   <= 1'b0;
            state_reg     <= NVDAR_IDLE;
            prdata_reg    <= 32'h00000000;
        end else begin
            addr_low_reg  <= addr_low_next;
            addr_high_reg <= addr_high_next;
            cleared_reg   <= cleared_next;
            state_reg     <= state_next;
            prdata_reg    <= prdata_next;
        end
    end

    // ------------------------------------------------------------
    // Data registers: kept through ordinary resets
    // ------------------------------------------------------------
    // No async reset so contents survive; power-on gives a defined value
    // in place of the unknown value real silicon would show.
    // Limitation: a write in the two cycles after power-on release is
    // lost while the synchronised level catches up
    always_ff @(posedge pclk) begin
        if (!por_sync) begin
            data_low_reg  <= NVDAR_DATA_POR;
            data_high_reg <= NVDAR_DATA_POR;
        end else begin
            data_low_reg  <= data_low_next;
            data_high_reg <= data_high_next;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn || !por_sync);

    a_data_high_top: assert property (data_high_reg[7:6] == 2'b00)
        else $error("High data unimplemented bits set");
    a_addr_high_top: assert property (addr_high_reg[7] == 1'b0)
        else $error("High address top bit set");
    // Software writes land on the edge after the access cycle, unless
    // a memory word is being taken at that same edge
    a_data_low_write: assert property (wr_stb && acc_addr == NVDAR_OFF_DATA_LOW
        && !(state_reg == NVDAR_WAIT && mem_done) |=> data_low_reg == $past(pwdata[7:0]))
        else $error("Low data write lost");
    a_data_high_write: assert property (wr_stb && acc_addr == NVDAR_OFF_DATA_HIGH
        && !(state_reg == NVDAR_WAIT && mem_done) |=> data_high_reg == {2'b00, $past(pwdata[5:0])})
        else $error("High data write wrong");
    a_addr_low_write: assert property (wr_stb && acc_addr == NVDAR_OFF_ADDRESS_LOW
        |=> addr_low_reg == $past(pwdata[7:0]))
        else $error("Low address write lost");
    a_addr_high_write: assert property (wr_stb && acc_addr == NVDAR_OFF_ADDRESS_HIGH
        |=> nvm_address_word[14:8] == $past(pwdata[6:0]))
        else $error("High address write wrong");

    // A memory word lands at the mem_done edge; out-of-range config
    // reads land as zero instead
    a_read_loads: assert property (state_reg == NVDAR_WAIT && mem_done
        && !(config_space_select && !cfg_readable(nvm_address_word))
        |=> nvm_data_word == $past(mem_rdata))
        else $error("Read word not loaded");
    a_range_clears: assert property (state_reg == NVDAR_WAIT && mem_done
        && config_space_select && !cfg_readable(nvm_address_word)
        |=> nvm_data_word == 14'h0000 && cleared_reg)
        else $error("Out of range read did not clear data");
    a_load_done: assert property (state_reg == NVDAR_LOAD |=> state_reg == NVDAR_IDLE)
        else $error("Sequencer stuck after load");

    // Holding behaviour: nothing but a write, a load or a read moves a register
    a_addr_hold: assert property (!(wr_stb && (acc_addr == NVDAR_OFF_ADDRESS_LOW
        || acc_addr == NVDAR_OFF_ADDRESS_HIGH)) |=> $stable(nvm_address_word))
        else $error("Address changed without a write");
    a_data_hold: assert property (!(wr_stb && (acc_addr == NVDAR_OFF_DATA_LOW
        || acc_addr == NVDAR_OFF_DATA_HIGH)) && !(state_reg == NVDAR_WAIT && mem_done)
        |=> $stable(nvm_data_word))
        else $error("Data changed without a write or load");
    a_prdata_hold: assert property (!rd_stb |=> $stable(prdata))
        else $error("Read data changed outside a read");
    a_status_upper: assert property (rd_stb && acc_addr == NVDAR_OFF_STATUS |=> prdata[31:2] == 30'h00000000)
        else $error("Status upper bits not zero");

    // Bus answers: writes at once, reads after one wait state
    a_unmapped_err: assert property (psel && penable && paddr > NVDAR_OFF_STATUS
        |-> ##[0:1] (pslverr && pready))
        else $error("Unmapped access not flagged");
    a_read_answer: assert property (psel && penable && !pwrite |-> ##[0:1] pready)
        else $error("Read not answered within one wait state");

    // Main scenarios the bench is expected to reach
    // Memory read completed, plain or config space
    c_read_done: cover property (state_reg == NVDAR_LOAD);
    // Config read outside the readable range
    c_range_clear: cover property (state_reg == NVDAR_LOAD && config_space_select && !cfg_readable(nvm_address_word));
    // Register set up shortly before a memory read
    c_write_then_read: cover property (wr_stb ##[1:20] rd_start);
    // Unmapped offset refused
    c_unmapped: cover property (pslverr);
    // Read stretched by its wait state
    c_read_wait: cover property (psel && penable && !pwrite && !pready);

endmodule
`default_nettype wire
